// File: logic/mmd_pkg.sv
// ==========================================================
// memory map decoder constants
package mmd_pkg;
	localparam int ADDR_W      = 18;  // host address incl. bits 16,17
	localparam int DATA_W      = 16;  // host data bus width
	localparam int BYTE_W      = 8;   // device data width
	localparam int SECTORS     = 8;   // flash sectors
	localparam int PAGE_W      = 3;   // page register width used
	localparam int SECT_LSB    = 14;  // 16k sector size
	localparam logic [17:0] CTRL_LAST  = 18'h000ff; // control block end
	localparam logic [17:0] WIN_LAST   = 18'h03fff; // overlay window end
	localparam logic [17:0] FLASH_LAST = 18'h1ffff; // 128k flat end
	localparam logic [7:0]  PAGE_OFS   = 8'he0;     // page register offset
	localparam logic [7:0]  PAGE_RST   = 8'h00;     // page reset value
	localparam logic [17:0] EXT_FIRST  = 18'h00200; // peripheral select start
	localparam logic [17:0] EXT_LAST   = 18'h00207; // peripheral select end
	localparam logic [15:0] OVL_BASE   = 16'h0000;  // overlay window base
	localparam logic [15:0] OVL_A13    = 16'h2000;  // host address line 13
endpackage

// File: logic/mmd_bus_if.sv
`timescale 1ns/1ps
// ==========================================================
// host memory bus between host end and device end
interface mmd_bus_if;
	import mmd_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic              io_strobe_n;
	logic              data_strobe_n;
	logic              byte_dma_strobe_n;
	logic              wr_n;
	logic              rd_n;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport host (
		output addr, io_strobe_n, data_strobe_n, byte_dma_strobe_n,
		output wr_n, rd_n, wdata,
		input  rdata
	);
	modport device (
		input  addr, io_strobe_n, data_strobe_n, byte_dma_strobe_n,
		input  wr_n, rd_n, wdata,
		output rdata
	);
endinterface

// File: logic/mmd_device.sv
`timescale 1ns/1ps
// Operation
// - control select for 0x00-0xff on io strobe only
// - host ignores upper byte of io transfers
// - byte dma shows flash as flat 128k
// - byte dma sector n at n*0x4000
// - overlay sector equals page, window 0x0000-0x3fff
// - host pages flash via page register
// - host widens window using address line 13
// - host ignores upper byte of data transfers
// - host unlocks, programs byte, checks status
// - byte dma accepts writes as well as reads
// - eight independent sector select outputs
// - address bits 16, 17 enter via port pins
// - optional peripheral chip select from decode
// - page register read/write at offset 0xe0
module mmd_device (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// host bus
	mmd_bus_if.device                        bus,
	// host address bits 16 and 17 on port pins
	input  wire logic [1:0]                  port_addr_hi,
	// decoded selects
	output logic                             ctrl_select_q,
	output logic [mmd_pkg::SECTORS-1:0]      flash_sector_select_q,
	output logic                             flash_write_q,
	output logic                             ext_select_q,
	output logic [mmd_pkg::PAGE_W-1:0]       page_q
);
	import mmd_pkg::*;

	// ==========================================================
	// internal nets
	// assembled host address
	logic [ADDR_W-1:0]  full_addr;
	// page register and its write enable
	logic [BYTE_W-1:0]  page_reg_q;
	logic               page_we;
	// strobe levels, active high inside the block
	logic               io_act;
	logic               dm_act;
	logic               bd_act;
	// exactly one strobe of the three active
	logic               io_only;
	logic               dm_only;
	logic               bd_only;
	// address ranges within the assembled address
	logic               in_ctrl_range;
	logic               in_win_range;
	logic               in_flash_range;
	logic               in_ext_range;
	// region hits
	logic               ctrl_hit;
	logic               page_hit;
	logic               win_hit;
	logic               flat_hit;
	logic               ext_hit;
	// sector indices for the two flash views
	logic [PAGE_W-1:0]  flat_sector;
	logic [PAGE_W-1:0]  ovl_sector;
	// per sector product terms and next selects
	logic [SECTORS-1:0] flat_term;
	logic [SECTORS-1:0] ovl_term;
	logic [SECTORS-1:0] sect_d;
	// next values of the remaining outputs
	logic               flash_hit;
	logic               host_write;
	logic               host_read;
	logic               flash_write_d;
	logic [BYTE_W-1:0]  rd_byte;
	logic [DATA_W-1:0]  rdata_d;

	// ==========================================================
	// address assembly
	// high bits come from port pins, low bits from the bus
	assign full_addr = {port_addr_hi, bus.addr[15:0]};

	// ==========================================================
	// strobe qualification
	// strobes arrive as active low levels
	assign io_act  = !bus.io_strobe_n;
	assign dm_act  = !bus.data_strobe_n;
	assign bd_act  = !bus.byte_dma_strobe_n;

	// two strobes at once is a host fault, so nothing answers then
	assign io_only = io_act && !dm_act && !bd_act;
	assign dm_only = dm_act && !io_act && !bd_act;
	assign bd_only = bd_act && !io_act && !dm_act;

	// ==========================================================
	// address ranges
	// ranges use the full address, port pin bits included, so a set
	// bit 16 or 17 leaves both the control block and the window
	assign in_ctrl_range  = (full_addr <= CTRL_LAST);
	assign in_win_range   = (full_addr <= WIN_LAST);
	assign in_flash_range = (full_addr <= FLASH_LAST);
	assign in_ext_range   = (full_addr >= EXT_FIRST)
		&& (full_addr <= EXT_LAST);

	// ==========================================================
	// region decode
	// control block and page register live in io space only
	assign ctrl_hit = io_only && in_ctrl_range;
	assign page_hit = ctrl_hit && (full_addr[7:0] == PAGE_OFS);
	assign page_we  = page_hit && host_write;
	// flash in the overlay window and in flat byte dma space
	assign win_hit  = dm_only && in_win_range;
	assign flat_hit = bd_only && in_flash_range;
	// optional peripheral select shares the io decode
	assign ext_hit  = io_only && in_ext_range;

	// ==========================================================
	// sector indices
	// flat view: address bits above one sector pick the sector
	assign flat_sector = full_addr[SECT_LSB+PAGE_W-1:SECT_LSB];
	// overlay view: the page register picks the sector
	assign ovl_sector  = page_reg_q[PAGE_W-1:0];

	// ==========================================================
	// per sector decode
	// each sector has a flat term and an overlay term, so one
	// sector can sit in both spaces at once
	genvar gi;
	generate
		for (gi = 0; gi < SECTORS; gi++) begin : g_sect
			// flat byte dma term, one 16k slice each
			assign flat_term[gi] = flat_hit
				&& (flat_sector == PAGE_W'(gi));
			// paged overlay term, the window shows the current page
			assign ovl_term[gi] = win_hit
				&& (ovl_sector == PAGE_W'(gi));
			// independent select per sector
			assign sect_d[gi] = flat_term[gi] || ovl_term[gi];
		end
	endgenerate

	// ==========================================================
	// output next values
	// host direction from its active low strobes
	assign host_write    = !bus.wr_n;
	assign host_read     = !bus.rd_n;
	// a write is flagged in either flash view
	assign flash_hit     = |sect_d;
	assign flash_write_d = flash_hit && host_write;
	// only the page register reads back, other offsets read zero
	assign rd_byte = (page_hit && host_read) ? page_reg_q : '0;
	// byte wide device, upper byte driven zero
	assign rdata_d = {{(DATA_W-BYTE_W){1'b0}}, rd_byte};

	// ==========================================================
	// page register, written over io space
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_reg_q <= PAGE_RST;
		end else if (page_we) begin
			page_reg_q <= bus.wdata[BYTE_W-1:0];
		end
	end

	// low page bits for outside, loaded with the register itself so
	// they never lag the overlay decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_q <= PAGE_RST[PAGE_W-1:0];
		end else if (page_we) begin
			page_q <= bus.wdata[PAGE_W-1:0];
		end
	end

	// ==========================================================
	// registered outputs
	// control block select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_select_q <= 1'b0;
		end else begin
			ctrl_select_q <= ctrl_hit;
		end
	end

	// flash sector selects
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_sector_select_q <= '0;
		end else begin
			flash_sector_select_q <= sect_d;
		end
	end

	// flash write flag, raised in both flash spaces
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_write_q <= 1'b0;
		end else begin
			flash_write_q <= flash_write_d;
		end
	end

	// peripheral select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_select_q <= 1'b0;
		end else begin
			ext_select_q <= ext_hit;
		end
	end

	// read data towards the host, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.rdata <= '0;
		end else begin
			bus.rdata <= rdata_d;
		end
	end
endmodule

// File: logic/mmd_host.sv
`timescale 1ns/1ps
// ==========================================================
// host end: drives one access per request, applies paging
module mmd_host (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// host bus
	mmd_bus_if.host                          bus,
	// address bits 16 and 17 to device port pins
	output logic [1:0]                       port_addr_hi,
	// user request
	input  wire logic                        req,
	input  wire logic                        req_write,
	input  wire logic [1:0]                  req_space,
	input  wire logic [mmd_pkg::ADDR_W-1:0]  req_addr,
	input  wire logic [7:0]                  req_wdata,
	input  wire logic                        req_ovl_hi,
	output logic                             busy_q,
	output logic                             done_q,
	output logic [7:0]                       rdata_q
);
	import mmd_pkg::*;

	typedef enum logic [1:0] {MMDH_IDLE, MMDH_ACC, MMDH_END} mmdh_state_t;
	mmdh_state_t state_q;
	logic [15:0] low_addr;

	// data overlay uses own line 13 under req_ovl_hi request control
	assign low_addr = (req_space == 2'd1)
		? ((req_addr[15:0] & 16'h1fff) | (req_ovl_hi ? OVL_A13 : OVL_BASE))
		: req_addr[15:0];

	// ==========================================================
	// access sequencer: space 0 io, 1 data overlay, 2 byte dma
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q               <= MMDH_IDLE;
			bus.addr              <= '0;
			bus.io_strobe_n       <= 1'b1;
			bus.data_strobe_n     <= 1'b1;
			bus.byte_dma_strobe_n <= 1'b1;
			bus.wr_n              <= 1'b1;
			bus.rd_n              <= 1'b1;
			bus.wdata             <= '0;
			port_addr_hi          <= '0;
			busy_q                <= 1'b0;
			done_q                <= 1'b0;
			rdata_q               <= '0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				MMDH_IDLE: begin
					if (req) begin
						bus.addr              <= {2'b00, low_addr};
						port_addr_hi          <= req_addr[17:16];
						bus.io_strobe_n       <= !(req_space == 2'd0);
						bus.data_strobe_n     <= !(req_space == 2'd1);
						bus.byte_dma_strobe_n <= !(req_space == 2'd2);
						bus.wr_n              <= !req_write;
						bus.rd_n              <= req_write;
						bus.wdata             <= {8'h00, req_wdata};
						busy_q                <= 1'b1;
						state_q               <= MMDH_ACC;
					end
				end
				MMDH_ACC: begin
					state_q <= MMDH_END;
				end
				MMDH_END: begin
					// low byte only kept
					rdata_q               <= bus.rdata[7:0];
					bus.io_strobe_n       <= 1'b1;
					bus.data_strobe_n     <= 1'b1;
					bus.byte_dma_strobe_n <= 1'b1;
					bus.wr_n              <= 1'b1;
					bus.rd_n              <= 1'b1;
					busy_q                <= 1'b0;
					done_q                <= 1'b1;
					state_q               <= MMDH_IDLE;
				end
			endcase
		end
	end
endmodule

// File: test/mmd_chk.sv
`timescale 1ns/1ps
// ====
// decode checks beside the host bus
module mmd_chk (
	// clock and reset
	input wire logic                        clk,
	input wire logic                        rst,
	// bus and selects
	input wire logic [mmd_pkg::ADDR_W-1:0]  addr,
	input wire logic                        io_strobe_n,
	input wire logic                        data_strobe_n,
	input wire logic                        byte_dma_strobe_n,
	input wire logic                        wr_n,
	input wire logic [mmd_pkg::DATA_W-1:0]  wdata,
	input wire logic [1:0]                  port_addr_hi,
	input wire logic                        ctrl_select_q,
	input wire logic [mmd_pkg::SECTORS-1:0] flash_sector_select_q,
	input wire logic                        flash_write_q,
	input wire logic                        ext_select_q,
	input wire logic [mmd_pkg::PAGE_W-1:0]  page_q
);
	import mmd_pkg::*;
	// exactly one strobe low, and address classes
	wire logic io1 = !io_strobe_n && data_strobe_n && byte_dma_strobe_n;
	wire logic dt1 = io_strobe_n && !data_strobe_n && byte_dma_strobe_n;
	wire logic dm1 = io_strobe_n && data_strobe_n && !byte_dma_strobe_n;
	wire logic lo  = port_addr_hi == 2'b00 && addr[15:0] <= 16'h00ff;
	wire logic pw  = io1 && lo && addr[7:0] == 8'he0 && !wr_n;
	wire logic pe  = io1 && port_addr_hi == 2'b00 && addr[15:0] >= 16'h0200
		&& addr[15:0] <= 16'h0207;
	wire logic ov  = dt1 && port_addr_hi == 2'b00 && addr[15:14] == 2'b00;
	wire logic [2:0] wd = wdata[2:0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence ovl_hit;
		ov;
	endsequence
	chk_ctrl_on: assert property (io1 && lo |=> ctrl_select_q)
		else $error("control select missing");
	chk_ctrl_off: assert property (!(io1 && lo) |=> !ctrl_select_q)
		else $error("stray control select");
	chk_dma_sect: assert property (dm1 && !port_addr_hi[1] |=>
		flash_sector_select_q == 8'h01 << {port_addr_hi[0], addr[15:14]})
		else $error("wrong byte dma sector");
	chk_ovl_sect: assert property (ovl_hit |=>
		flash_sector_select_q == 8'h01 << $past(page_q))
		else $error("wrong overlay sector");
	chk_none_sel: assert property (!(io1 || dt1 || dm1) |=>
		flash_sector_select_q == 8'h00 && !ctrl_select_q && !ext_select_q)
		else $error("select without single strobe");
	chk_page_wr: assert property (pw |=> page_q == $past(wd))
		else $error("page write lost");
	chk_page_hold: assert property (!pw |=> $stable(page_q))
		else $error("page changed without write");
	chk_dma_write: assert property (
		dm1 && !wr_n && !port_addr_hi[1] |=> flash_write_q)
		else $error("byte dma write not flagged");
	chk_ovl_write: assert property (ov && !wr_n |=>
		flash_write_q)
		else $error("overlay write not flagged");
	chk_ext_on: assert property (pe |=> ext_select_q)
		else $error("peripheral select missing");
	chk_ext_off: assert property (!pe |=> !ext_select_q)
		else $error("stray peripheral select");
	chk_one_sect: assert property ($onehot0(flash_sector_select_q))
		else $error("several sectors selected");
endmodule

// File: test/mmd_tb.sv
`timescale 1ns/1ps
// ====
// both ends joined, user side driven at falling edge
module mmd_tb;
	import mmd_pkg::*;
	logic clk = 0, rst = 1, req = 0, req_write = 0, req_ovl_hi = 0;
	logic [1:0] req_space = 0, port_addr_hi;
	logic [17:0] req_addr = 0, snap;
	logic [7:0] req_wdata = 0, rdata_q, flash_sector_select_q;
	logic busy_q, done_q, ctrl_select_q, flash_write_q, ext_select_q;
	logic [2:0] page_q;
	int n_mismatch = 0, checked = 0, cyc = 0;
	mmd_bus_if bus ();
	mmd_host mmd_host_inst (.clk, .rst, .bus(bus.host), .port_addr_hi, .req,
		.req_write, .req_space, .req_addr, .req_wdata, .req_ovl_hi, .busy_q,
		.done_q, .rdata_q);
	mmd_device mmd_device_inst (.clk, .rst, .bus(bus.device), .port_addr_hi,
		.ctrl_select_q, .flash_sector_select_q, .flash_write_q, .ext_select_q,
		.page_q);
	mmd_chk mmd_chk_inst (.clk, .rst, .addr(bus.addr), .wr_n(bus.wr_n),
		.io_strobe_n(bus.io_strobe_n), .data_strobe_n(bus.data_strobe_n),
		.byte_dma_strobe_n(bus.byte_dma_strobe_n), .wdata(bus.wdata),
		.port_addr_hi, .ctrl_select_q, .flash_sector_select_q, .flash_write_q,
		.ext_select_q, .page_q);
	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one host access; snap holds selects seen mid-access
	task automatic acc(input logic w, input logic [1:0] sp,
		input logic [17:0] a, input logic [7:0] d, input logic ov);
		int i;
		{req_write, req_space, req_addr, req_wdata, req_ovl_hi} = {w, sp, a, d, ov};
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		repeat (2) @(negedge clk);
		snap = {flash_write_q, ext_select_q, ctrl_select_q, flash_sector_select_q};
		for (i = 0; i < 8 && done_q !== 1'b1; i++) @(negedge clk);
		cmp(done_q, 1'b1);
		@(negedge clk);
	endtask
	task automatic t_io;
		acc(1, 0, 18'h000e0, 8'h05, 0);
		cmp(snap, 18'h100);
		cmp(page_q, 3'h5);
		acc(0, 0, 18'h000e0, 8'h00, 0);
		cmp(rdata_q, 8'h05);
		acc(0, 0, 18'h00100, 8'h00, 0);
		cmp(snap, 18'h000);
		acc(0, 0, 18'h00207, 8'h00, 0);
		cmp(snap, 18'h200);
		acc(0, 0, 18'h00208, 8'h00, 0);
		cmp(snap, 18'h000);
		acc(1, 3, 18'h000e0, 8'h07, 0);
		cmp(snap, 18'h000);
		cmp(page_q, 3'h5);
	endtask
	// byte by byte overlay programming, status read after each byte
	task automatic t_prog;
		acc(1, 0, 18'h000e0, 8'h02, 0);
		for (int b = 0; b < 2; b++) begin
			acc(1, 1, {17'h00008, b[0]}, 8'h5a, 0);
			cmp(snap, 18'h404);
			acc(0, 1, {17'h00008, b[0]}, 8'h00, 0);
			cmp(snap, 18'h004);
		end
	endtask
	task automatic t_dma;
		for (int n = 0; n < 8; n++) begin
			acc(0, 2, {n[2:0], 14'h3fff}, 8'h00, 0);
			cmp(snap, 18'h1 << n);
		end
		acc(1, 2, 18'h1c000, 8'ha5, 0);
		cmp(snap, 18'h480);
		acc(0, 2, 18'h20000, 8'h00, 0);
		cmp(snap, 18'h000);
	endtask
	task automatic t_ovl;
		for (int p = 0; p < 8; p++) begin
			acc(1, 0, 18'h000e0, p[7:0], 0);
			acc(0, 1, 18'h01fff, 8'h00, 1);
			cmp(snap, 18'h1 << p);
		end
		cmp({ctrl_select_q, flash_sector_select_q}, 18'h0);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_io();
		t_dma();
		t_ovl();
		t_prog();
		end_of_test();
	end
endmodule
